/* File: rtl/fre_top.sv */
// serial programming port with row erase and code write sequencing
//
// Rules for this block and its programmer
// [R01] Transfers are 4-bit command then 16-bit operand, LSB first, captured on falling clock.
// [R02] Command 0000 runs operand as core instruction; 0010 shifts latch out on data pin.
// [R03] Control register: flash select 7, config select 6, row erase 4, write enable 2, start 1.
// [R04] Erase one 64-byte row only when not code or write protected.
// [R05] Rows sit on 64-byte boundaries from address zero to end of memory.
// [R06] Any byte address inside a row erases that whole row.
// [R07] Erase begins on the fourth clock of the second no-operation after start.
// [R08] Erase is timed inside; hardware clears the start bit when done.
// [R09] Programmer polls start bit via latch copy, no-operation and shift-out.
// [R10] Programmer holds clock low for discharge time after erase.
// [R11] Programmer first sets flash select, clears config select, sets write enable.
// [R12] For full erase programmer clears all three pointer bytes first.
// [R13] Programmer sets row erase select, then start bit, by core instructions.
// [R14] Programmer repeats erase, poll, discharge, stepping pointer by 64.
// [R15] Erase size is always 64 bytes; write buffer is 64, 32 or 16.
// [R16] Buffer maps to aligned region; programming writes region holding the pointer.
// [R17] Programmer loads pointer bytes by literal load then store.
// [R18] Command 1101 loads two buffer bytes then adds two to the pointer.
// [R19] Command 1111 loads final two bytes and arms programming; zero no-operation follows.
// [R20] Programming lasts while the fourth clock of that no-operation stays high.
// [R21] Programming ends on clock fall; programmer keeps clock low for discharge.
// [R22] Pointer must stay in the loaded buffer region when programming starts.
// [R23] Programmer repeats point, load, program for further data.
// [R24] Programmer clears write enable when finished.
`include "fre_map.svh"
module fre_top #(
  parameter int unsigned ERASE_CYCLES = (`FRE_ERASE_NS + `FRE_CLK_NS - 1) / `FRE_CLK_NS
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // serial programming pins
  input  wire logic        prog_clock_pin_i,
  input  wire logic        prog_data_pin_i,
  output logic             prog_data_pin_o,
  output logic             prog_data_pin_oe_o,
  // register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [31:0]      reg_rdata_o,
  // sequencer state
  output logic             erase_busy_o,
  output logic             prog_active_o
);
  import fre_pkg::*;

  fre_top_t    st_ff;
  fre_top_t    nxt_st;
  logic        ck_ok;
  logic        dt_lvl;
  logic        rise;
  logic        fall;
  logic        exec;
  logic        allow;
  logic [15:0] word;
  logic [2:0]  oidx;

  fre_arr_if arr_if ();

  // ****************************************************************
  // special function register read
  // ****************************************************************
  function automatic logic [7:0] sfr_rd(input fre_top_t s, input logic [7:0] f);
    logic [7:0] v;
    v = 8'h00;
    unique case (f)
      `FRE_F_CTRL:  v = s.ctrl;
      `FRE_F_LATCH: v = s.latch;
      `FRE_F_PTRL:  v = s.ptr[7:0];
      `FRE_F_PTRH:  v = s.ptr[15:8];
      `FRE_F_PTRU:  v = {2'h0, s.ptr[21:16]};
      default:      v = 8'h00;
    endcase
    return v;
  endfunction

  // ****************************************************************
  // pin edges: a change counts when second and third stage agree
  // ****************************************************************
  assign ck_ok  = (st_ff.ck_s[1] == st_ff.ck_s[2]);
  assign dt_lvl = (st_ff.dt_s[1] == st_ff.dt_s[2]) ? st_ff.dt_s[2] : st_ff.dt;
  assign rise   = ck_ok && st_ff.ck_s[2] && !st_ff.ck;
  assign fall   = ck_ok && !st_ff.ck_s[2] && st_ff.ck;
  assign exec   = fall && (st_ff.bits == `FRE_LAST_BIT);
  assign word   = {dt_lvl, st_ff.opnd[15:1]};
  assign oidx   = 3'(st_ff.bits - `FRE_OUT_FIRST);
  // code memory, write enabled, block unprotected
  assign allow  = st_ff.ctrl[`FRE_B_FLASH] && !st_ff.ctrl[`FRE_B_CFG] &&
                  st_ff.ctrl[`FRE_B_WRITE_ENABLE_BIT] && (st_ff.prot == 2'h0); // R03 R04

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic       wen;
    logic [7:0] wval;
    logic [7:0] f;
    wen    = 1'b0;
    wval   = 8'h00;
    f      = word[7:0];
    nxt_st = st_ff;
    nxt_st.ck_s  = {st_ff.ck_s[1:0], prog_clock_pin_i};
    nxt_st.dt_s  = {st_ff.dt_s[1:0], prog_data_pin_i};
    nxt_st.dt    = dt_lvl;
    nxt_st.ers   = 1'b0;
    nxt_st.ld    = 1'b0;
    nxt_st.prg   = 1'b0;
    nxt_st.rdata = 32'h0000_0000;
    if (ck_ok) nxt_st.ck = st_ff.ck_s[2];

    // bit capture, command then operand
    if (fall) begin
      if (st_ff.bits < `FRE_CMD_BITS) nxt_st.cmd = {dt_lvl, st_ff.cmd[3:1]}; // R01
      else nxt_st.opnd = word;
      nxt_st.bits = exec ? 5'h00 : st_ff.bits + 5'h01;
    end

    // latch shift-out in the second operand byte
    if (rise && (st_ff.cmd == `FRE_CMD_SHOUT) && (st_ff.bits >= `FRE_OUT_FIRST)) begin
      nxt_st.doe  = 1'b1; // R02
      nxt_st.dout = st_ff.latch[oidx];
    end
    if (exec) nxt_st.doe = 1'b0;

    // sequencer
    unique case (st_ff.seq)
      FRE_IDLE: ;
      FRE_ARM1: begin
        if (exec) nxt_st.seq = FRE_ARM2;
      end
      FRE_ARM2: begin
        if (rise && (st_ff.bits == `FRE_START_CLK)) begin
          if (allow) begin
            nxt_st.ers = 1'b1; // R07 R04
            nxt_st.seq = FRE_ERASE;
          end else begin
            nxt_st.ctrl[`FRE_B_WR] = 1'b0;
            nxt_st.seq = FRE_IDLE;
          end
        end
      end
      FRE_ERASE: begin
        if (arr_if.done) begin
          nxt_st.ctrl[`FRE_B_WR] = 1'b0; // R08
          nxt_st.seq = FRE_IDLE;
        end
      end
      FRE_PARM: begin
        if (rise && (st_ff.bits == `FRE_START_CLK)) nxt_st.seq = allow ? FRE_PROG : FRE_IDLE; // R20
      end
      FRE_PROG: begin
        if (fall) begin
          nxt_st.prg = 1'b1; // R21
          nxt_st.seq = FRE_IDLE;
        end
      end
    endcase

    // core instruction execution
    if (exec && (st_ff.cmd == `FRE_CMD_CORE)) begin
      if (word[15:8] == `FRE_OP_MOVLW) nxt_st.wreg = word[7:0]; // R02
      else if (word[15:8] == `FRE_OP_MOVWF) begin
        wen  = 1'b1;
        wval = st_ff.wreg;
      end else if (word[15:8] == `FRE_OP_CLRF) begin
        wen  = 1'b1;
        wval = 8'h00;
      end else if (word[15:8] == `FRE_OP_MOVF) nxt_st.wreg = sfr_rd(st_ff, f);
      else if ((word[15:12] == `FRE_OP_BSF) || (word[15:12] == `FRE_OP_BCF)) begin
        wen  = 1'b1;
        wval = sfr_rd(st_ff, f);
        wval[word[11:9]] = (word[15:12] == `FRE_OP_BSF);
      end
    end
    if (wen) begin
      unique case (f)
        `FRE_F_CTRL: begin
          // start bit: set only with write enable and row erase, never cleared by software
          // keep a hardware clear of the start bit made in this same cycle
          nxt_st.ctrl = {wval[7:2], nxt_st.ctrl[`FRE_B_WR], wval[0]}; // R03 R08
          if (!st_ff.ctrl[`FRE_B_WR] && wval[`FRE_B_WR] && st_ff.ctrl[`FRE_B_WRITE_ENABLE_BIT] &&
              wval[`FRE_B_ROW] && (st_ff.seq == FRE_IDLE)) begin
            nxt_st.ctrl[`FRE_B_WR] = 1'b1;
            nxt_st.seq = FRE_ARM1;
          end
        end
        `FRE_F_LATCH: nxt_st.latch = wval;
        `FRE_F_PTRL:  nxt_st.ptr[7:0] = wval;
        `FRE_F_PTRH:  nxt_st.ptr[15:8] = wval;
        `FRE_F_PTRU:  nxt_st.ptr[21:16] = wval[5:0];
        default: ;
      endcase
    end

    // table writes into the buffer
    if (exec && ((st_ff.cmd == `FRE_CMD_TWINC) || (st_ff.cmd == `FRE_CMD_TWPRG))) begin
      nxt_st.ld     = 1'b1;
      nxt_st.ld_off = {st_ff.ptr[`FRE_WBUF_LSB-1:1], 1'b0};
      nxt_st.ld_dat = word;
      if (st_ff.cmd == `FRE_CMD_TWINC) nxt_st.ptr = st_ff.ptr + `FRE_PTR_STEP; // R18
      else if (st_ff.seq == FRE_IDLE) nxt_st.seq = FRE_PARM; // R19
    end

    // register port
    if (reg_wr_i) begin
      if (reg_addr_i == `FRE_REG_PROT) nxt_st.prot = reg_wdata_i[1:0];
      if (reg_addr_i == `FRE_REG_ADDR) nxt_st.raddr = reg_wdata_i[`FRE_MEM_AW-1:0];
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `FRE_REG_PROT: nxt_st.rdata = {30'h0000_0000, st_ff.prot};
        `FRE_REG_STAT: nxt_st.rdata = {st_ff.pact, st_ff.busy, st_ff.ptr, st_ff.ctrl};
        `FRE_REG_ADDR: nxt_st.rdata = {22'h00_0000, st_ff.raddr};
        `FRE_REG_DATA: nxt_st.rdata = {24'h00_0000, arr_if.rd_data};
        default:       nxt_st.rdata = 32'h0000_0000;
      endcase
    end
    nxt_st.busy = (nxt_st.seq == FRE_ERASE);
    nxt_st.pact = (nxt_st.seq == FRE_PROG);
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff     <= '0;
      st_ff.seq <= FRE_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs and array hookup
  assign prog_data_pin_o    = st_ff.dout;
  assign prog_data_pin_oe_o = st_ff.doe;
  assign reg_rdata_o        = st_ff.rdata;
  assign erase_busy_o       = st_ff.busy;
  assign prog_active_o      = st_ff.pact;
  assign arr_if.erase_req   = st_ff.ers;
  assign arr_if.load_req    = st_ff.ld;
  assign arr_if.load_off    = st_ff.ld_off;
  assign arr_if.load_data   = st_ff.ld_dat;
  assign arr_if.prog_req    = st_ff.prg;
  assign arr_if.ptr         = st_ff.ptr;
  assign arr_if.rd_addr     = st_ff.raddr;

  // flash array
  fre_array #(
    .ERASE_CYCLES (ERASE_CYCLES)
  ) u_array (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .arr_io   (arr_if.arr)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_erase_go;
    (st_ff.seq == FRE_ARM2) && rise && (st_ff.bits == `FRE_START_CLK) && allow;
  endsequence
  sequence s_prog_end;
    (st_ff.seq == FRE_PROG) && fall;
  endsequence

  property p_cmd_lsb;
    @(posedge clk_i) disable iff (!resetn_i)
    fall && (st_ff.bits < `FRE_CMD_BITS) |=> st_ff.cmd[3] == $past(dt_lvl);
  endproperty
  a_cmd_lsb: assert property (p_cmd_lsb) else $error("command bit not captured"); // R01

  property p_out_bit;
    @(posedge clk_i) disable iff (!resetn_i)
    st_ff.doe && st_ff.ck |-> (st_ff.cmd == `FRE_CMD_SHOUT) && (st_ff.dout == st_ff.latch[oidx]);
  endproperty
  a_out_bit: assert property (p_out_bit) else $error("wrong latch bit driven"); // R02

  property p_erase_start;
    @(posedge clk_i) disable iff (!resetn_i)
    s_erase_go |=> st_ff.ers && (st_ff.seq == FRE_ERASE) ##1 !st_ff.ers;
  endproperty
  a_erase_start: assert property (p_erase_start) else $error("erase not started on fourth clock"); // R07

  property p_erase_gate;
    @(posedge clk_i) disable iff (!resetn_i)
    st_ff.ers |-> st_ff.ctrl[`FRE_B_FLASH] && !st_ff.ctrl[`FRE_B_CFG] && (st_ff.prot == 2'h0);
  endproperty
  a_erase_gate: assert property (p_erase_gate) else $error("erase of protected or wrong space"); // R04

  property p_erase_end;
    @(posedge clk_i) disable iff (!resetn_i)
    (st_ff.seq == FRE_ERASE) && arr_if.done |=> !st_ff.ctrl[`FRE_B_WR] && !st_ff.busy;
  endproperty
  a_erase_end: assert property (p_erase_end) else $error("start bit not cleared after erase"); // R08

  property p_ptr_step;
    @(posedge clk_i) disable iff (!resetn_i)
    exec && (st_ff.cmd == `FRE_CMD_TWINC) |=> st_ff.ptr == $past(st_ff.ptr) + `FRE_PTR_STEP;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer not advanced by two"); // R18

  property p_prog_hold;
    @(posedge clk_i) disable iff (!resetn_i)
    st_ff.pact |-> st_ff.ck && (st_ff.seq == FRE_PROG);
  endproperty
  a_prog_hold: assert property (p_prog_hold) else $error("programming with clock low"); // R20

  property p_prog_end;
    @(posedge clk_i) disable iff (!resetn_i)
    s_prog_end |=> st_ff.prg && !st_ff.pact ##1 !st_ff.prg;
  endproperty
  a_prog_end: assert property (p_prog_end) else $error("programming not ended on clock fall"); // R21
endmodule

/* File: common/fre_map.svh */
// command codes, field positions, register offsets and timing figures of the sequencer
`ifndef FRE_MAP_SVH
`define FRE_MAP_SVH
`define FRE_CMD_CORE  4'h0
`define FRE_CMD_SHOUT 4'h2
`define FRE_CMD_TWINC 4'hD
`define FRE_CMD_TWPRG 4'hF
`define FRE_CMD_BITS  5'h04
`define FRE_LAST_BIT  5'h13
`define FRE_OUT_FIRST 5'h0C
`define FRE_START_CLK 5'h03
`define FRE_B_FLASH   7
`define FRE_B_CFG     6
`define FRE_B_ROW     4
`define FRE_B_WRITE_ENABLE_BIT    2
`define FRE_B_WR      1
`define FRE_OP_MOVLW  8'h0E
`define FRE_OP_MOVWF  8'h6E
`define FRE_OP_CLRF   8'h6A
`define FRE_OP_MOVF   8'h50
`define FRE_OP_BSF    4'h8
`define FRE_OP_BCF    4'h9
`define FRE_F_CTRL    8'hA6
`define FRE_F_LATCH   8'hF5
`define FRE_F_PTRL    8'hF6
`define FRE_F_PTRH    8'hF7
`define FRE_F_PTRU    8'hF8
`define FRE_ROW_LSB   6
`define FRE_WBUF_LSB  6
`define FRE_WBUF_SZ   64
`define FRE_MEM_AW    10
`define FRE_PTR_W     22
`define FRE_PTR_STEP  22'h000002
`define FRE_REG_PROT  4'h0
`define FRE_REG_STAT  4'h1
`define FRE_REG_ADDR  4'h2
`define FRE_REG_DATA  4'h3
`define FRE_ERASE_NS  100000
`define FRE_CLK_NS    10
`endif

/* File: common/fre_pkg.sv */
// types of the row erase and code write sequencer
`include "fre_map.svh"
package fre_pkg;
  typedef enum logic [5:0] {
    FRE_IDLE  = 6'h01,
    FRE_ARM1  = 6'h02,
    FRE_ARM2  = 6'h04,
    FRE_ERASE = 6'h08,
    FRE_PARM  = 6'h10,
    FRE_PROG  = 6'h20
  } fre_seq_t;
  typedef struct packed {
    logic [2:0]             ck_s;
    logic [2:0]             dt_s;
    logic                   ck;
    logic                   dt;
    logic [4:0]             bits;
    logic [3:0]             cmd;
    logic [15:0]            opnd;
    logic [7:0]             wreg;
    logic [7:0]             ctrl;
    logic [`FRE_PTR_W-1:0]  ptr;
    logic [7:0]             latch;
    fre_seq_t               seq;
    logic                   dout;
    logic                   doe;
    logic [1:0]             prot;
    logic [`FRE_MEM_AW-1:0] raddr;
    logic [31:0]            rdata;
    logic                   ers;
    logic                   ld;
    logic [5:0]             ld_off;
    logic [15:0]            ld_dat;
    logic                   prg;
    logic                   busy;
    logic                   pact;
  } fre_top_t;
  typedef struct packed {
    logic [31:0]            cnt;
    logic                   busy;
    logic                   done;
    logic [`FRE_PTR_W-1:0]  base;
  } fre_arr_t;
endpackage

/* File: common/fre_arr_if.sv */
// carrier between the serial sequencer and the flash array
interface fre_arr_if;
  logic                   erase_req;
  logic                   load_req;
  logic [5:0]             load_off;
  logic [15:0]            load_data;
  logic                   prog_req;
  logic [21:0]            ptr;
  logic                   done;
  logic [9:0]             rd_addr;
  logic [7:0]             rd_data;
  modport ctrl (output erase_req, load_req, load_off, load_data, prog_req, ptr, rd_addr, input done, rd_data);
  modport arr  (input erase_req, load_req, load_off, load_data, prog_req, ptr, rd_addr, output done, rd_data);
endinterface

/* File: rtl/fre_array.sv */
// program flash array with write buffer and self-timed row erase
`include "fre_map.svh"
module fre_array #(
  parameter int unsigned ERASE_CYCLES = 1
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // sequencer side
  fre_arr_if.arr    arr_io
);
  import fre_pkg::*;
  localparam int unsigned MEM_SZ = 1 << `FRE_MEM_AW;
  fre_arr_t   st_ff;
  fre_arr_t   nxt_st;
  logic [7:0] mem  [0:MEM_SZ-1];
  logic [7:0] wbuf [0:`FRE_WBUF_SZ-1];
  logic       fin;
  logic       in_mem;

  assign fin            = st_ff.busy && (st_ff.cnt == ERASE_CYCLES - 1);
  assign in_mem         = (arr_io.ptr[`FRE_PTR_W-1:`FRE_MEM_AW] == '0);
  assign arr_io.done    = st_ff.done;
  assign arr_io.rd_data = mem[arr_io.rd_addr];

  // erase timer: the row base is the pointer with its low bits dropped
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    if (st_ff.busy) begin
      nxt_st.cnt = st_ff.cnt + 32'h1;
      if (fin) begin
        nxt_st.busy = 1'b0; // R08
        nxt_st.done = 1'b1;
      end
    end else if (arr_io.erase_req) begin
      nxt_st.busy = 1'b1;
      nxt_st.cnt  = '0;
      nxt_st.base = {arr_io.ptr[`FRE_PTR_W-1:`FRE_ROW_LSB], `FRE_ROW_LSB'(0)}; // R05 R06 R15
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) st_ff <= '0;
    else st_ff <= nxt_st;
  end

  // write buffer: two bytes per load, back to erased state after a program
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < `FRE_WBUF_SZ; i++) wbuf[i] <= 8'hFF;
    end else if (arr_io.prog_req) begin
      for (int i = 0; i < `FRE_WBUF_SZ; i++) wbuf[i] <= 8'hFF;
    end else if (arr_io.load_req) begin
      wbuf[arr_io.load_off]        <= arr_io.load_data[7:0];
      wbuf[arr_io.load_off | 6'h01] <= arr_io.load_data[15:8];
    end
  end

  // array cells: erase sets a row to ones, programming only clears bits
  always_ff @(posedge clk_i) begin
    if (fin && (st_ff.base[`FRE_PTR_W-1:`FRE_MEM_AW] == '0)) begin
      for (int i = 0; i < (1 << `FRE_ROW_LSB); i++)
        mem[{st_ff.base[`FRE_MEM_AW-1:`FRE_ROW_LSB], `FRE_ROW_LSB'(i)}] <= 8'hFF; // R04
    end else if (arr_io.prog_req && in_mem) begin
      for (int i = 0; i < `FRE_WBUF_SZ; i++)
        mem[{arr_io.ptr[`FRE_MEM_AW-1:`FRE_WBUF_LSB], `FRE_WBUF_LSB'(i)}] <=
          mem[{arr_io.ptr[`FRE_MEM_AW-1:`FRE_WBUF_LSB], `FRE_WBUF_LSB'(i)}] & wbuf[i]; // R16
    end
  end
endmodule

/* File: bench/fre_prog_model.sv */
// programmer model: drives the serial clock and data pins of the programming port
module fre_prog_model (
  // system clock used as time base
  input  wire logic clk_i,
  // device side of the data pin
  input  wire logic dev_data_i,
  input  wire logic dev_oe_i,
  // serial pins
  output logic      prog_clock_pin_o,
  output logic      prog_data_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic drv_d_ff;  // level the programmer drives
  logic drv_oe_ff; // programmer owns the data pin

  // resolved wire: device first, then programmer, else the inverse of the last level
  assign prog_data_pin_o = dev_oe_i ? dev_data_i : (drv_oe_ff ? drv_d_ff : ~drv_d_ff);

  // pins idle low from time zero
  initial begin
    prog_clock_pin_o = 1'b0;
    drv_d_ff = 1'b0;
    drv_oe_ff = 1'b1;
  end

  // wait a number of system clock cycles
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one transfer of command then operand; hi4 stretches the 4th clock, lo_end idles low after
  task automatic xfer(input logic [3:0] cmd, input logic [15:0] opnd, input int hi4, input int lo_end,
                      output logic [7:0] rd);
    logic [19:0] bits;
    bits = {opnd, cmd};
    rd = 8'h00;
    for (int k = 0; k < 20; k++) begin
      @(posedge clk_i);
      prog_clock_pin_o <= 1'b1;
      drv_d_ff <= bits[k];
      drv_oe_ff <= (cmd != 4'h2) || (k < 12);
      wait_n((k == 3) ? hi4 : 8);
      if (k >= 12) begin
        rd[k-12] = prog_data_pin_o;
      end
      prog_clock_pin_o <= 1'b0;
      wait_n(7);
    end
    wait_n(lo_end);
  endtask
endmodule

/* File: bench/test_flash_row_erase_program.sv */
// self-checking bench of the row erase and code write sequencer
module test_flash_row_erase_program;
  timeunit 1ns;
  timeprecision 1ps;
  import fre_pkg::*;

  localparam int ERASE_N = 20;
  localparam int HOLD_N  = 60;
  localparam int DIS_N   = 40;

  logic        clk_i;
  logic        resetn_i;
  logic        prog_clock_pin;
  logic        prog_data_pin;
  logic        dev_d;
  logic        dev_oe;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        busy;
  logic        pact;
  logic [7:0]  rd;
  logic [31:0] v;
  int          n_fail;
  int          compares;
  int          busy_cnt;
  int          pact_cnt;
  int          p0;

  fre_top #(.ERASE_CYCLES(ERASE_N)) fre_top_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .prog_clock_pin_i(prog_clock_pin), .prog_data_pin_i(prog_data_pin),
    .prog_data_pin_o(dev_d), .prog_data_pin_oe_o(dev_oe), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .erase_busy_o(busy), .prog_active_o(pact));

  fre_prog_model fre_prog_model_inst (
    .clk_i(clk_i), .dev_data_i(dev_d), .dev_oe_i(dev_oe), .prog_clock_pin_o(prog_clock_pin), .prog_data_pin_o(prog_data_pin));

  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // count cycles of erase and of programming
  initial begin
    busy_cnt = 0;
    pact_cnt = 0;
  end
  always @(posedge clk_i) begin
    busy_cnt <= busy_cnt + int'(busy === 1'b1);
    pact_cnt <= pact_cnt + int'(pact === 1'b1);
  end

  // verdict and end of run
  task automatic stop_test;
    if (n_fail == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // compare and report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // register port write and read
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_i);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_i);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // one serial transfer
  task automatic ser(input logic [3:0] c, input logic [15:0] op, input int hi4 = 8, input int lo = 0);
    fre_prog_model_inst.xfer(c, op, hi4, lo, rd);
  endtask

  // pointer load by literal and store, upper then high then low
  task automatic set_ptr(input logic [21:0] a);
    ser(4'h0, {8'h0E, 2'h0, a[21:16]});
    ser(4'h0, 16'h6EF8);
    ser(4'h0, {8'h0E, a[15:8]});
    ser(4'h0, 16'h6EF7);
    ser(4'h0, {8'h0E, a[7:0]});
    ser(4'h0, 16'h6EF6);
  endtask

  // row erase, two no-operations, poll of the start bit, then discharge
  task automatic erase(input int exp_busy);
    int b0;
    b0 = busy_cnt;
    ser(4'h0, 16'h88A6);
    ser(4'h0, 16'h82A6);
    ser(4'h0, 16'h0000);
    chk("early erase", 32'h0, 32'(busy_cnt - b0));
    ser(4'h0, 16'h0000);
    // busy also spans the request and done hand-off cycles
    chk("erase cycles", 32'(exp_busy == 0 ? 0 : exp_busy + 2), 32'(busy_cnt - b0));
    ser(4'h0, 16'h50A6);
    ser(4'h0, 16'h6EF5);
    ser(4'h0, 16'h0000);
    ser(4'h2, 16'h0000, 8, DIS_N);
    chk("start bit", 32'h0, {31'h0, rd[1]});
    chk("flash select", 32'h1, {31'h0, rd[7]});
  endtask

  // expected byte of the written pattern
  function automatic logic [7:0] pat(input int i);
    return 8'(i * 3 + 1);
  endfunction

  // read back one 64-byte row through the register port
  task automatic chk_row(input logic [9:0] base, input logic erased);
    logic [31:0] d;
    for (int i = 0; i < 64; i++) begin
      reg_write(4'h2, 32'(base) + 32'(i));
      reg_read(4'h3, d);
      chk("array byte", erased ? 32'h0000_00FF : 32'(pat(i)), d);
    end
  endtask

  // bound on the whole run
  initial begin
    repeat (90000) @(posedge clk_i);
    n_fail++;
    stop_test();
  end

  // main sequence
  initial begin
    n_fail = 0;
    compares = 0;
    resetn_i = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    reg_read(4'h1, v);
    chk("status after reset", 32'h0, v);
    reg_write(4'h9, 32'hFFFF_FFFF);
    reg_read(4'h9, v);
    chk("unmapped index", 32'h0, v);
    // code memory access and write enable
    ser(4'h0, 16'h8EA6);
    ser(4'h0, 16'h9CA6);
    ser(4'h0, 16'h84A6);
    reg_read(4'h1, v);
    chk("control byte", 32'h84, {24'h0, v[7:0]});
    // clear all three pointer bytes, first row
    set_ptr(22'h000123);
    ser(4'h0, 16'h6AF8);
    ser(4'h0, 16'h6AF7);
    ser(4'h0, 16'h6AF6);
    reg_read(4'h1, v);
    chk("pointer cleared", 32'h0, {10'h0, v[29:8]});
    // erase with the pointer inside the second row
    set_ptr(22'h000047);
    reg_read(4'h1, v);
    chk("pointer", 32'h47, {10'h0, v[29:8]});
    erase(ERASE_N);
    chk_row(10'h040, 1'b1);
    // fill the write buffer and program the row
    set_ptr(22'h000040);
    for (int k = 0; k < 31; k++) begin
      ser(4'hD, {pat(2 * k + 1), pat(2 * k)});
    end
    reg_read(4'h1, v);
    chk("pointer after loads", 32'h7E, {10'h0, v[29:8]});
    ser(4'hF, {pat(63), pat(62)});
    reg_read(4'h1, v);
    chk("pointer after last load", 32'h7E, {10'h0, v[29:8]});
    p0 = pact_cnt;
    ser(4'h0, 16'h0000, HOLD_N, DIS_N);
    chk("program time", 32'h1, 32'((pact_cnt - p0 >= HOLD_N - 2) && (pact_cnt - p0 <= HOLD_N + 2)));
    chk_row(10'h040, 1'b0);
    // protected row is left alone, code then write protection
    for (int p = 1; p < 3; p++) begin
      reg_write(4'h0, 32'(p));
      reg_read(4'h0, v);
      chk("protect", 32'(p), v);
      erase(0);
      chk_row(10'h040, 1'b0);
    end
    reg_write(4'h0, 32'h0);
    // pointer left at byte 7E by the last load erases the whole row
    erase(ERASE_N);
    chk_row(10'h040, 1'b1);
    // writes disabled: erase is refused
    ser(4'h0, 16'h94A6);
    reg_read(4'h1, v);
    chk("write enable", 32'h0, {31'h0, v[2]});
    erase(0);
    stop_test();
  end
endmodule
